/* rtl/regulator_control_defs.svh */
/*
 Register offsets, field positions and reset values of the regulator
 control bank. Assumes inclusion from rtl/ by bare name.
*/
`ifndef REGULATOR_CONTROL_DEFS_SVH
`define REGULATOR_CONTROL_DEFS_SVH

`define ADDR_LDO_ONE      8'h6C
`define ADDR_LDO_TWO      8'h6D
`define ADDR_BOOST        8'h66
`define ADDR_FRONT_LDO    8'h67
`define ADDR_MEM_REF      8'h68
`define ADDR_BACKUP       8'h69

`define BOOST_STBY_HI     6
`define BOOST_STBY_LO     5
`define BOOST_MODE_HI     3
`define BOOST_MODE_LO     2
`define BOOST_VOLT_HI     1
`define BOOST_VOLT_LO     0
`define BOOST_MASK        8'h6F
`define FRONT_MASK        8'h01
`define MEMREF_MASK       8'h01
`define BACKUP_MASK       8'h07
`define LDO_MASK          8'hFF

`define LDO_OFF_MODE_BIT  7
`define LDO_LOWPWR_BIT    6
`define LDO_STBY_OFF_BIT  5
`define LDO_ENABLE_BIT    4
`define LDO_VOLT_HI       3
`define LDO_VOLT_LO       0
`define LDO_UPPER_RESET   3'h0

`define BACKUP_VOLT_3V0   3'h6
`define BOOST_MODE_AUTO   2'h2
`define ZERO_BYTE         8'h00

`endif

/* rtl/regulator_control_pkg.sv */
/*
 Types shared by the regulator control bank. Assumes nothing else.
*/
package regulator_control_pkg;

    typedef enum logic [1:0] {
        SW_OFF   = 2'b00,
        SW_PFM   = 2'b01,
        SW_AUTO  = 2'b10,
        SW_SKIP  = 2'b11
    } boost_mode_e;

    typedef struct packed {
        logic       off_mode;
        logic       lowpower_en;
        logic       standby_off;
        logic       enable;
        logic [3:0] voltage;
    } ldo_ctrl_s;

    typedef struct packed {
        boost_mode_e standby_mode;
        boost_mode_e normal_mode;
        logic [1:0]  voltage_sel;
    } boost_ctrl_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;

    typedef struct packed {
        logic       active;
        logic       pfm;
        logic       skip;
    } boost_drive_s;

    // Reset image from programmable memory
    typedef struct packed {
        logic [1:0] boost_volt;
        logic       front_no_lowpower;
        logic       mem_ref_en;
        logic       ldo_one_en;
        logic [3:0] ldo_one_volt;
        logic       ldo_two_en;
        logic [3:0] ldo_two_volt;
    } otp_image_s;

endpackage

/* rtl/boost_mode_ctrl.sv */
/*
 Boost switching mode resolver: picks the active mode code from normal
 or standby field, resolves automatic mode by load, and drives the
 switching style. Assumes load_heavy is synchronous to sys_clk.
*/
`timescale 1ns/100ps
`include "regulator_control_defs.svh"

module boost_mode_ctrl
    import regulator_control_pkg::*;
(
    input  wire logic                         sys_clk,
    input  wire logic                         rstn,
    input  wire regulator_control_pkg::boost_ctrl_s  ctrl,
    input  wire logic                         standby,
    input  wire logic                         load_heavy,
    output regulator_control_pkg::boost_drive_s      drive
);

    typedef struct packed {
        boost_drive_s drive;
    } state_s;

    state_s s_q;
    state_s s_d;
    boost_mode_e sel;

    // Standby field governs while in standby, else normal field
    always_comb
    begin
        sel = standby ? ctrl.standby_mode : ctrl.normal_mode;
        s_d = s_q;
        unique case (sel)
            SW_OFF:  s_d.drive = 3'b000;
            SW_PFM:  s_d.drive = 3'b110;
            SW_AUTO: s_d.drive = load_heavy ? 3'b101 : 3'b110;
            SW_SKIP: s_d.drive = 3'b101;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign drive = s_q.drive;

    auto_follows_load_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (sel == SW_AUTO) |=> (drive.skip == $past(load_heavy)))
        else $error("auto mode did not follow load");

endmodule

/* rtl/regulator_control_regs.sv */
/*
 Register bank for boost, front-end regulator, memory reference,
 backup supply and two linear regulators. Fields drive control outputs.
 Assumes a simple strobe master on sys_clk; otp_image is stable while
 otp_load pulses after reset release.
*/
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`include "regulator_control_defs.svh"

module regulator_control_regs
    import regulator_control_pkg::*;
(
    input  wire logic                              sys_clk,
    input  wire logic                              rstn,
    input  wire logic [7:0]                        reg_addr,
    input  wire logic [7:0]                        reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output logic [7:0]                             reg_rdata,
    input  wire regulator_control_pkg::otp_image_s otp_image,
    input  wire logic                              otp_load,
    input  wire logic                              startup_boost_en,
    input  wire logic                              standby,
    input  wire logic                              load_heavy,
    output regulator_control_pkg::boost_ctrl_s     boost_ctrl,
    output regulator_control_pkg::boost_drive_s    boost_drive,
    output logic                                   front_ldo_no_lowpower,
    output logic                                   mem_reference_enable,
    output logic [2:0]                             backup_supply_voltage,
    output regulator_control_pkg::ldo_ctrl_s       ldo_one,
    output regulator_control_pkg::ldo_ctrl_s       ldo_two
);

    typedef struct packed {
        boost_ctrl_s boost;
        logic        front;
        logic        memref;
        logic [2:0]  backup;
        ldo_ctrl_s   ldo1;
        ldo_ctrl_s   ldo2;
        logic [7:0]  rdata;
        logic        start_q;
    } state_s;

    state_s s_q;
    state_s s_d;
    reg_req_s req;

    // Decode used for both write and read paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // Read mux; unmapped addresses and unused bits give zero
    function automatic logic [7:0] read_word(input state_s s, input logic [7:0] a);
        read_word = `ZERO_BYTE;
        if (hit(a, `ADDR_BOOST))
            read_word = {1'b0, s.boost.standby_mode, 1'b0,
                         s.boost.normal_mode, s.boost.voltage_sel};
        if (hit(a, `ADDR_FRONT_LDO))
            read_word = {7'h00, s.front};
        if (hit(a, `ADDR_MEM_REF))
            read_word = {7'h00, s.memref};
        if (hit(a, `ADDR_BACKUP))
            read_word = {5'h00, s.backup};
        if (hit(a, `ADDR_LDO_ONE))
            read_word = s.ldo1;
        if (hit(a, `ADDR_LDO_TWO))
            read_word = s.ldo2;
    endfunction

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Next-state: OTP load, start-up mode force, then software write
    always_comb
    begin
        s_d = s_q;
        s_d.start_q = startup_boost_en;
        if (otp_load)
        begin
            s_d.boost.voltage_sel = otp_image.boost_volt;
            s_d.front             = otp_image.front_no_lowpower;
            s_d.memref            = otp_image.mem_ref_en;
            s_d.ldo1.enable       = otp_image.ldo_one_en;
            s_d.ldo1.voltage      = otp_image.ldo_one_volt;
            s_d.ldo2.enable       = otp_image.ldo_two_en;
            s_d.ldo2.voltage      = otp_image.ldo_two_volt;
        end
        // Rising start-up enable places boost in auto mode
        if (startup_boost_en && !s_q.start_q)
            s_d.boost.normal_mode = boost_mode_e'(`BOOST_MODE_AUTO);
        if (req.wr)
        begin
            if (hit(req.addr, `ADDR_BOOST))
            begin
                s_d.boost.standby_mode =
                    boost_mode_e'(req.wdata[`BOOST_STBY_HI:`BOOST_STBY_LO]);
                s_d.boost.normal_mode  =
                    boost_mode_e'(req.wdata[`BOOST_MODE_HI:`BOOST_MODE_LO]);
                s_d.boost.voltage_sel  = req.wdata[`BOOST_VOLT_HI:`BOOST_VOLT_LO];
            end
            if (hit(req.addr, `ADDR_FRONT_LDO))
                s_d.front = req.wdata[0];
            if (hit(req.addr, `ADDR_MEM_REF))
                s_d.memref = req.wdata[0];
            // Every code other than 110 (3.0 V) is dropped, keeping the supply at 3.0 V
            if (hit(req.addr, `ADDR_BACKUP) && req.wdata[2:0] == `BACKUP_VOLT_3V0)
                s_d.backup = req.wdata[2:0];
            if (hit(req.addr, `ADDR_LDO_ONE))
                s_d.ldo1 = req.wdata;
            if (hit(req.addr, `ADDR_LDO_TWO))
                s_d.ldo2 = req.wdata;
        end
        s_d.rdata = req.rd ? read_word(s_q, req.addr) : `ZERO_BYTE;
    end

    // Register the whole state; upper LDO bits and backup code fixed at reset
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_q <= '0;
            s_q.backup <= `BACKUP_VOLT_3V0;
            s_q.ldo1[7:5] <= `LDO_UPPER_RESET;
            s_q.ldo2[7:5] <= `LDO_UPPER_RESET;
        end
        else
            s_q <= s_d;
    end

    // Outputs straight from state flops
    assign boost_ctrl            = s_q.boost;
    assign front_ldo_no_lowpower = s_q.front;
    assign mem_reference_enable  = s_q.memref;
    assign backup_supply_voltage = s_q.backup;
    assign ldo_one               = s_q.ldo1;
    assign ldo_two               = s_q.ldo2;
    assign reg_rdata             = s_q.rdata;

    // Switching style generator
    boost_mode_ctrl u_boost (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .ctrl       (s_q.boost),
        .standby    (standby),
        .load_heavy (load_heavy),
        .drive      (boost_drive)
    );

    ldo_one_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (reg_wr && reg_addr == `ADDR_LDO_ONE && !otp_load) |=> (ldo_one == $past(reg_wdata)))
        else $error("first ldo write lost");

    ldo_two_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (reg_wr && reg_addr == `ADDR_LDO_TWO && !otp_load) |=> (ldo_two == $past(reg_wdata)))
        else $error("second ldo write lost");

    backup_code_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        backup_supply_voltage == `BACKUP_VOLT_3V0)
        else $error("backup code left 110");

    front_bit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (reg_wr && reg_addr == `ADDR_FRONT_LDO && !otp_load)
        |=> (front_ldo_no_lowpower == $past(reg_wdata[0])))
        else $error("front bit not written");

    memref_bit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (reg_wr && reg_addr == `ADDR_MEM_REF && !otp_load)
        |=> (mem_reference_enable == $past(reg_wdata[0])))
        else $error("reference enable not written");

    boost_fields_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (reg_wr && reg_addr == `ADDR_BOOST && !otp_load)
        |=> (boost_ctrl.standby_mode == $past(reg_wdata[6:5])
             && boost_ctrl.voltage_sel == $past(reg_wdata[1:0])))
        else $error("boost fields not written");

    startup_auto_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        ($rose(startup_boost_en) && !(reg_wr && reg_addr == `ADDR_BOOST))
        |=> (boost_ctrl.normal_mode == SW_AUTO))
        else $error("start-up did not pick auto");

    read_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (reg_rd && reg_addr == `ADDR_MEM_REF) |=> (reg_rdata[7:1] == 7'h00))
        else $error("unused bits read nonzero");

    otp_load_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (otp_load && !reg_wr) |=> (ldo_one.voltage == $past(otp_image.ldo_one_volt)))
        else $error("otp value not loaded");

endmodule

/* dv/regulator_control_regs_bench.sv */
/*
 Self-checking bench for the regulator control register bank.
 Assumes the bank answers reads one cycle after the strobe and that
 the boost drive settles within three cycles of its inputs changing.
*/
`timescale 1ns/100ps
`include "regulator_control_defs.svh"

module regulator_control_regs_bench;
    import regulator_control_pkg::*;

    logic         sys_clk = 1'b0;
    logic         rstn = 1'b0;
    logic [7:0]   reg_addr = 8'h00;
    logic [7:0]   reg_wdata = 8'h00;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic [7:0]   reg_rdata;
    otp_image_s   otp_image = '0;
    logic         otp_load = 1'b0;
    logic         startup_boost_en = 1'b0;
    logic         standby = 1'b0;
    logic         load_heavy = 1'b0;
    boost_ctrl_s  boost_ctrl;
    boost_drive_s boost_drive;
    logic         front_ldo_no_lowpower;
    logic         mem_reference_enable;
    logic [2:0]   backup_supply_voltage;
    ldo_ctrl_s    ldo_one;
    ldo_ctrl_s    ldo_two;
    int           err_count = 0;
    int           tests_run = 0;

    regulator_control_regs regulator_control_regs_i (
        .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .otp_image(otp_image),
        .otp_load(otp_load), .startup_boost_en(startup_boost_en), .standby(standby),
        .load_heavy(load_heavy), .boost_ctrl(boost_ctrl), .boost_drive(boost_drive),
        .front_ldo_no_lowpower(front_ldo_no_lowpower),
        .mem_reference_enable(mem_reference_enable),
        .backup_supply_voltage(backup_supply_voltage), .ldo_one(ldo_one), .ldo_two(ldo_two)
    );

    // Free-running 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    // Byte comparison; narrower results are zero-extended by the caller
    task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // One-cycle write strobe; outputs are settled on return
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    // One-cycle read strobe; data sampled in the single cycle it stands
    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        check_val(reg_rdata, exp, "read data");
    endtask

    // Expected switching style: {active, pfm, skip}
    function automatic logic [7:0] drive_for(input logic [1:0] code, input logic heavy);
        case (code)
            2'h1:    drive_for = 8'h06;
            2'h2:    drive_for = heavy ? 8'h05 : 8'h06;
            2'h3:    drive_for = 8'h05;
            default: drive_for = 8'h00;
        endcase
    endfunction

    task automatic test_reset;
        check_val({5'h00, backup_supply_voltage}, 8'h06, "backup out");
        check_val(ldo_one, 8'h00, "ldo one out");
        reg_read(`ADDR_LDO_TWO, 8'h00);
        reg_read(`ADDR_BACKUP, 8'h06);
        $display("test reset done");
    endtask

    task automatic test_otp;
        // Image changes on a rising edge like every other input
        @(posedge sys_clk);
        otp_image <= '{boost_volt: 2'h3, front_no_lowpower: 1'b1, mem_ref_en: 1'b1,
                       ldo_one_en: 1'b1, ldo_one_volt: 4'hA, ldo_two_en: 1'b0,
                       ldo_two_volt: 4'h5};
        @(posedge sys_clk);
        otp_load <= 1'b1;
        @(posedge sys_clk);
        otp_load <= 1'b0;
        @(posedge sys_clk);
        #1;
        check_val(ldo_one, 8'h1A, "otp ldo one");
        check_val(ldo_two, 8'h05, "otp ldo two");
        check_val({6'h00, boost_ctrl.voltage_sel}, 8'h03, "otp boost volt");
        check_val({6'h00, front_ldo_no_lowpower, mem_reference_enable}, 8'h03, "otp bits");
        reg_read(`ADDR_LDO_ONE, 8'h1A);
        $display("test otp done");
    endtask

    task automatic test_ldo;
        logic [7:0] pat [4] = '{8'h95, 8'h6A, 8'hFF, 8'h00};
        for (int i = 0; i < 4; i++)
        begin
            reg_write(`ADDR_LDO_ONE, pat[i]);
            check_val(ldo_one, pat[i], "ldo one out");
            reg_write(`ADDR_LDO_TWO, ~pat[i]);
            check_val(ldo_two, ~pat[i], "ldo two out");
            check_val(ldo_one, pat[i], "ldo one kept");
            reg_read(`ADDR_LDO_ONE, pat[i]);
            reg_read(`ADDR_LDO_TWO, ~pat[i]);
        end
        $display("test ldo done");
    endtask

    task automatic test_boost;
        logic [1:0] nm;
        logic [1:0] sm;
        logic [7:0] d;
        for (int i = 0; i < 4; i++)
        begin
            nm = 2'(i);
            sm = 2'(3 - i);
            d  = {1'b1, sm, 1'b1, nm, nm};
            reg_write(`ADDR_BOOST, d);
            check_val(boost_ctrl, {2'h0, sm, nm, nm}, "boost fields");
            reg_read(`ADDR_BOOST, {1'b0, sm, 1'b0, nm, nm});
            for (int j = 0; j < 4; j++)
            begin
                @(posedge sys_clk);
                standby    <= j[1];
                load_heavy <= j[0];
                repeat (3) @(posedge sys_clk);
                #1;
                check_val(boost_drive, drive_for(j[1] ? sm : nm, j[0]), "boost drive");
            end
            @(posedge sys_clk);
            standby    <= 1'b0;
            load_heavy <= 1'b0;
        end
        $display("test boost done");
    endtask

    task automatic test_startup;
        reg_write(`ADDR_BOOST, 8'h61);
        @(posedge sys_clk);
        startup_boost_en <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        check_val(boost_ctrl, 8'h39, "startup auto");
        @(posedge sys_clk);
        startup_boost_en <= 1'b0;
        $display("test startup done");
    endtask

    task automatic test_misc;
        reg_write(`ADDR_FRONT_LDO, 8'hFE);
        check_val({7'h00, front_ldo_no_lowpower}, 8'h00, "front out low");
        reg_write(`ADDR_FRONT_LDO, 8'hFF);
        check_val({7'h00, front_ldo_no_lowpower}, 8'h01, "front out high");
        reg_read(`ADDR_FRONT_LDO, 8'h01);
        reg_write(`ADDR_MEM_REF, 8'h00);
        check_val({7'h00, mem_reference_enable}, 8'h00, "memref off");
        reg_write(`ADDR_MEM_REF, 8'hFF);
        check_val({7'h00, mem_reference_enable}, 8'h01, "memref on");
        reg_read(`ADDR_MEM_REF, 8'h01);
        reg_write(`ADDR_BACKUP, 8'h05);
        check_val({5'h00, backup_supply_voltage}, 8'h06, "backup kept");
        reg_read(`ADDR_BACKUP, 8'h06);
        reg_write(8'h70, 8'hFF);
        reg_read(8'h70, 8'h00);
        @(posedge sys_clk);
        #1;
        check_val(reg_rdata, 8'h00, "read data after");
        $display("test misc done");
    endtask

    // Counts, verdict and end of run
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        test_reset();
        test_otp();
        test_ldo();
        test_boost();
        test_startup();
        test_misc();
        close_out();
    end

    // Watchdog far beyond the roughly 160 cycles the tests need
    initial
    begin
        #500000;
        err_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        close_out();
    end
endmodule
